// ---- logic/csrw_regs.vh ----
`ifndef CSRW_REGS_VH
`define CSRW_REGS_VH

// ----------------------------------------------------------------
// Timing figures in their own units
// ----------------------------------------------------------------
`define CSRW_CLK_HZ          200000000
`define CSRW_TICK_US         1000
`define CSRW_MR_IGNORE_MS    1
`define CSRW_MR_QUALIFY_MS   20
`define CSRW_WD_SHORT_MS     150
`define CSRW_WD_MID_MS       600
`define CSRW_WD_LONG_MS      1200
`define CSRW_RST_HOLD_MS     610
`define CSRW_STROBE_NS       75
`define CSRW_CLK_NS          5

// ----------------------------------------------------------------
// Derived cycle counts
// ----------------------------------------------------------------
`define CSRW_TICK_CYC        ((`CSRW_CLK_HZ / 1000000) * `CSRW_TICK_US)
`define CSRW_STROBE_CYC      ((`CSRW_STROBE_NS + `CSRW_CLK_NS - 1) / `CSRW_CLK_NS)

// ----------------------------------------------------------------
// Period select encodings
// ----------------------------------------------------------------
`define CSRW_SEL_GND         2'b00
`define CSRW_SEL_OPEN        2'b01
`define CSRW_SEL_VCC         2'b10

`endif

// ---- logic/csrw_supervisor.v ----
// Summary of operation
// (R1) Manual reset lows under 1 ms ignored
// (R2) Manual reset low 20 ms forces reset
// (R3) Period select picks 150/600/1200 ms
// (R4) Tolerance select picks 5 or 10 percent
// (R5) Active-high reset on any of three causes
// (R6) Open-drain active-low reset, same causes
// (R7) Reset held one timeout after cause ends
// (R8) Supply fail asserts both resets
// (R9) Missing strobe edge in period asserts reset
// (R10) Strobe falling edge restarts watchdog count
// (R11) Host strobes within every watchdog period
// (R12) Millisecond tick; watchdog cleared during reset
// (R13) Manual input sampled every clock, must stay low
`timescale 1ns/1ps
`default_nettype none
`include "csrw_regs.vh"

module csrw_supervisor #(
  parameter integer TICK_CYC    = `CSRW_TICK_CYC,
  parameter integer MR_QUAL_MS  = `CSRW_MR_QUALIFY_MS,
  parameter integer RST_HOLD_MS = `CSRW_RST_HOLD_MS,
  parameter integer WD_SHORT_MS = `CSRW_WD_SHORT_MS,
  parameter integer WD_MID_MS   = `CSRW_WD_MID_MS,
  parameter integer WD_LONG_MS  = `CSRW_WD_LONG_MS
) (
  input  wire       ref_clk_i,
  input  wire       rst_n_i,
  input  wire       manual_reset_in_n_i,
  input  wire [1:0] watchdog_period_select_i,
  input  wire       supply_tolerance_select_i,
  input  wire       supply_fail_5pct_i,
  input  wire       supply_fail_10pct_i,
  input  wire       watchdog_strobe_in_i,
  output reg        reset_o,
  output wire       reset_n_o,
  output wire       reset_n_oe_o
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Watchdog period in milliseconds for a select code
  function [10:0] wd_period_ms;
    input [1:0] sel;
    begin
      case (sel)
        `CSRW_SEL_GND:  wd_period_ms = WD_SHORT_MS[10:0];  // R3
        `CSRW_SEL_OPEN: wd_period_ms = WD_MID_MS[10:0];    // R3
        `CSRW_SEL_VCC:  wd_period_ms = WD_LONG_MS[10:0];   // R3
        default:        wd_period_ms = WD_LONG_MS[10:0];   // R3
      endcase
    end
  endfunction

  // True once a rising count sits one step short of its limit
  function at_last;
    input [10:0] count;
    input [10:0] limit;
    begin
      at_last = (count >= limit - 11'h001);
    end
  endfunction

  // ----------------------------------------------------------------
  // Millisecond time base
  // ----------------------------------------------------------------
  // Divider state
  reg  [17:0] tick_cnt;
  reg  [17:0] next_tick_cnt;
  wire        tick = (tick_cnt == TICK_CYC[17:0] - 18'h0_0001);

  // Wrap the divider on the tick, otherwise step it
  always @* begin
    if (tick) begin
      next_tick_cnt = 18'h0_0000;  // R12
    end else begin
      next_tick_cnt = tick_cnt + 18'h0_0001;
    end
  end

  // Free-running divider producing one pulse per millisecond
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_cnt <= 18'h0_0000;
    end else begin
      tick_cnt <= next_tick_cnt;
    end
  end

  // ----------------------------------------------------------------
  // Manual reset debounce
  // ----------------------------------------------------------------
  // Debounce state
  reg  [4:0] mr_low_ms;
  reg        mr_active;
  reg  [4:0] next_mr_low_ms;
  reg        next_mr_active;
  wire       mr_qualified = at_last({6'h00, mr_low_ms}, {6'h00, MR_QUAL_MS[4:0]});

  // Count whole ticks of continuous low; any high sample restarts
  always @* begin
    next_mr_low_ms = mr_low_ms;
    next_mr_active = mr_active;
    if (manual_reset_in_n_i) begin
      next_mr_low_ms = 5'h00;  // R1
      next_mr_active = 1'b0;
    end else if (tick) begin
      if (mr_qualified) begin
        next_mr_active = 1'b1;  // R2 R13
      end else begin
        next_mr_low_ms = mr_low_ms + 5'h01;  // R13
      end
    end
  end

  // Debounce registers
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mr_low_ms <= 5'h00;
      mr_active <= 1'b0;
    end else begin
      mr_low_ms <= next_mr_low_ms;
      mr_active <= next_mr_active;
    end
  end

  // ----------------------------------------------------------------
  // Supply fail selection
  // ----------------------------------------------------------------
  // Tolerance select low picks the 5 percent comparator
  wire supply_bad = supply_tolerance_select_i ? supply_fail_10pct_i
                                              : supply_fail_5pct_i;  // R4 R8

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  // Watchdog state
  reg         strobe_q;
  reg  [10:0] wd_ms;
  reg         wd_expired;
  reg  [10:0] next_wd_ms;
  reg         next_wd_expired;
  wire [10:0] wd_limit    = wd_period_ms(watchdog_period_select_i);  // R3
  wire        strobe_fall = strobe_q & ~watchdog_strobe_in_i;

  // Restart on falling strobe; held clear while reset is out
  always @* begin
    next_wd_ms      = wd_ms;
    next_wd_expired = 1'b0;
    if (reset_o || strobe_fall) begin
      next_wd_ms = 11'h000;  // R10 R12
    end else if (tick) begin
      if (at_last(wd_ms, wd_limit)) begin
        next_wd_expired = 1'b1;  // R9
        next_wd_ms      = 11'h000;
      end else begin
        next_wd_ms = wd_ms + 11'h001;
      end
    end
  end

  // Watchdog registers; strobe history idles high like its pin
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strobe_q   <= 1'b1;
      wd_ms      <= 11'h000;
      wd_expired <= 1'b0;
    end else begin
      strobe_q   <= watchdog_strobe_in_i;
      wd_ms      <= next_wd_ms;
      wd_expired <= next_wd_expired;
    end
  end

  // ----------------------------------------------------------------
  // Reset output stretch
  // ----------------------------------------------------------------
  // Hold state
  reg  [9:0] hold_ms;
  reg  [9:0] next_hold_ms;
  reg        next_reset;
  wire       hold_last = (hold_ms <= 10'h001);
  wire       cause     = supply_bad | mr_active | wd_expired;

  // Any cause reloads the hold time; outputs drop after it runs out
  always @* begin
    next_reset   = reset_o;
    next_hold_ms = hold_ms;
    if (cause) begin
      next_reset   = 1'b1;  // R5 R8 R9
      next_hold_ms = RST_HOLD_MS[9:0];  // R7
    end else if (reset_o && tick) begin
      if (hold_last) begin
        next_reset   = 1'b0;  // R7
        next_hold_ms = 10'h000;
      end else begin
        next_hold_ms = hold_ms - 10'h001;
      end
    end
  end

  // Reset output and hold registers
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reset_o <= 1'b1;
      hold_ms <= RST_HOLD_MS[9:0];
    end else begin
      reset_o <= next_reset;
      hold_ms <= next_hold_ms;
    end
  end

  // ----------------------------------------------------------------
  // Reset pins
  // ----------------------------------------------------------------
  // Data side of the open-drain pin is always low
  assign reset_n_o    = 1'b0;     // R6

  // Enable pulls the line only while reset is asserted
  assign reset_n_oe_o = reset_o;  // R6

endmodule // csrw_supervisor
`default_nettype wire

// ---- verification/cpu_supervisor_reset_watchdog_test.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, v) begin compares++; if ((v) !== (e)) begin n_mismatch++; \
  $display("Error %s expected %0h seen %0h", nm, e, v); end end
// ----
// Bench top
// ----
module cpu_supervisor_reset_watchdog_test;
  localparam integer T = 20;
  logic ref_clk_i = 1'h0, rst_n_i = 1'h0, manual_reset_in_n_i = 1'h1, run = 1'h0;
  logic supply_tolerance_select_i = 1'h0, supply_fail_5pct_i = 1'h0, supply_fail_10pct_i = 1'h0;
  logic [1:0] watchdog_period_select_i = 2'h0;
  wire logic watchdog_strobe_in_i, reset_o, reset_n_o, reset_n_oe_o;
  integer n_mismatch = 0, compares = 0;
  always #2.5 ref_clk_i = !ref_clk_i;
  csrw_supervisor #(.TICK_CYC(T), .MR_QUAL_MS(3), .RST_HOLD_MS(4), .WD_SHORT_MS(5),
    .WD_MID_MS(8), .WD_LONG_MS(12)) csrw_supervisor_inst (.ref_clk_i, .rst_n_i,
    .manual_reset_in_n_i, .watchdog_period_select_i, .supply_tolerance_select_i,
    .supply_fail_5pct_i, .supply_fail_10pct_i, .watchdog_strobe_in_i, .reset_o,
    .reset_n_o, .reset_n_oe_o);
  csrw_host csrw_host_inst (.ref_clk_i, .run_i(run), .strobe_o(watchdog_strobe_in_i));
  task automatic w(input integer n);
    repeat (n) @(negedge ref_clk_i);
  endtask
  // Unselected comparator ignored, selected one resets
  task automatic t_supply(input logic supply_tolerance_select);
    supply_tolerance_select_i = supply_tolerance_select;
    {supply_fail_10pct_i, supply_fail_5pct_i} = supply_tolerance_select ? 2'h1 : 2'h2;
    w(4); `CHK("other fail", 1'h0, reset_o)
    {supply_fail_10pct_i, supply_fail_5pct_i} = supply_tolerance_select ? 2'h2 : 2'h1;
    w(2); `CHK("supply", 1'h1, reset_o)
    `CHK("pins", 2'h1, {reset_n_o, reset_n_oe_o})
    {supply_fail_10pct_i, supply_fail_5pct_i} = 2'h0;
    w(3 * T - 2); `CHK("hold", 1'h1, reset_o)
    w(T + 4); `CHK("release", 1'h0, reset_o)
  endtask
  // Short press ignored, long press resets
  task automatic t_manual;
    manual_reset_in_n_i = 1'h0;
    w(T - 2); manual_reset_in_n_i = 1'h1;
    w(4 * T); `CHK("short", 1'h0, reset_o)
    manual_reset_in_n_i = 1'h0;
    w(4 * T + 4); `CHK("long", 1'h1, reset_o)
    manual_reset_in_n_i = 1'h1;
    w(4 * T + 4); `CHK("unpress", 1'h0, reset_o)
  endtask
  // Strobing keeps quiet, silence expires per select
  task automatic t_wd(input logic [1:0] sel, input integer ms);
    watchdog_period_select_i = sel;
    run = 1'h1;
    w(13 * T); `CHK("strobed", 1'h0, reset_o)
    run = 1'h0;
    w(ms * T - T - 20); `CHK("early", 1'h0, reset_o)
    w(T + 30); `CHK("expiry", 1'h1, reset_o)
    run = 1'h1;
    w(5 * T); `CHK("recover", 1'h0, reset_o)
  endtask
  task automatic complete_run;
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Main sequence and watchdog
  initial begin
    fork begin #100000; n_mismatch++; complete_run; end join_none
    run = 1'h1;
    w(12); `CHK("in reset", 2'h1, {reset_n_o, reset_n_oe_o})
    rst_n_i = 1'h1;
    w(5 * T); `CHK("boot", 1'h0, reset_o)
    t_supply(1'h0);
    t_supply(1'h1);
    t_manual;
    t_wd(2'h0, 5);
    t_wd(2'h1, 8);
    t_wd(2'h2, 12);
    complete_run;
  end
endmodule // cpu_supervisor_reset_watchdog_test
bind csrw_supervisor csrw_checker #(.TICK_CYC(TICK_CYC), .MR_QUAL_MS(MR_QUAL_MS),
  .WD_SHORT_MS(WD_SHORT_MS), .WD_MID_MS(WD_MID_MS),
  .WD_LONG_MS(WD_LONG_MS)) csrw_checker_inst (.ref_clk_i, .rst_n_i, .manual_reset_in_n_i,
  .watchdog_strobe_in_i, .watchdog_period_select_i, .supply_tolerance_select_i,
  .supply_fail_5pct_i, .supply_fail_10pct_i, .reset_o, .reset_n_o, .reset_n_oe_o);
`default_nettype wire

// ---- verification/csrw_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----
// Reset output checks
// ----
module csrw_checker #(parameter integer TICK_CYC = 20, MR_QUAL_MS = 3, WD_SHORT_MS = 5,
  WD_MID_MS = 8, WD_LONG_MS = 12) (
  input wire logic       ref_clk_i,
  input wire logic       rst_n_i,
  input wire logic       manual_reset_in_n_i,
  input wire logic       watchdog_strobe_in_i,
  input wire logic [1:0] watchdog_period_select_i,
  input wire logic       supply_tolerance_select_i,
  input wire logic       supply_fail_5pct_i,
  input wire logic       supply_fail_10pct_i,
  input wire logic       reset_o,
  input wire logic       reset_n_o,
  input wire logic       reset_n_oe_o);
  localparam int WD_SPAN = 2 * TICK_CYC + 8;
  integer mc, wc;
  wire logic sup = supply_tolerance_select_i ? supply_fail_10pct_i : supply_fail_5pct_i;
  // Silent cycles after which the selected period may first run out
  wire integer wd_early = (watchdog_period_select_i == 2'h0 ? WD_SHORT_MS :
    watchdog_period_select_i == 2'h1 ? WD_MID_MS : WD_LONG_MS) * TICK_CYC - TICK_CYC;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Cycles of manual low and of strobe silence
  always @(posedge ref_clk_i or negedge rst_n_i)
    if (!rst_n_i) begin
      mc <= 0;
      wc <= 0;
    end else begin
      mc <= manual_reset_in_n_i ? 0 : mc + 1;
      wc <= (reset_o || $fell(watchdog_strobe_in_i)) ? 0 : wc + 1;
    end
  sup_five_a: assert property (!supply_tolerance_select_i && supply_fail_5pct_i |=> reset_o)
    else $error("sup5");
  sup_ten_a: assert property (supply_tolerance_select_i && supply_fail_10pct_i |=> reset_o)
    else $error("sup10");
  oe_link_a: assert property (reset_n_oe_o == reset_o) else $error("oe");
  drive_low_a: assert property (reset_n_o == 1'h0) else $error("drv");
  hold_min_a: assert property ($rose(reset_o) |-> reset_o[*8]) else $error("hold");
  release_cause_a: assert property ($fell(reset_o) |-> !$past(sup)) else $error("rel");
  manual_qual_a: assert property (mc > MR_QUAL_MS * TICK_CYC + 8 |-> reset_o)
    else $error("mr");
  wd_expire_a: assert property (!reset_o && wc == wd_early |-> ##[0:WD_SPAN] reset_o)
    else $error("wd");
endmodule // csrw_checker
`default_nettype wire

// ---- verification/csrw_host.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----
// Host strobing the watchdog
// ----
module csrw_host (
  input  wire logic ref_clk_i,
  input  wire logic run_i,
  output var  logic strobe_o);
  logic [3:0] n = 4'h0;
  // Pin idles high before the first edge
  initial strobe_o = 1'h1;
  // One low cycle in sixteen while running, idle high
  always @(negedge ref_clk_i) begin
    n <= run_i ? n + 4'h1 : 4'h0;
    strobe_o <= !(run_i && n == 4'hF);
  end
endmodule // csrw_host
`default_nettype wire
